// [logic/pews_cfg.svh]
// named constants of the page write host controller: register map, op codes, timing
// assumes a 125 MHz clock and a byte-wide page-mode flash on the far side of the pins
`ifndef PEWS_CFG_SVH
`define PEWS_CFG_SVH

// register byte offsets on the apb side
`define PEWS_REG_CMD 12'h000
`define PEWS_REG_ADDR 12'h004
`define PEWS_REG_WDATA 12'h008
`define PEWS_REG_STATUS 12'h00C
`define PEWS_REG_RDATA 12'h010

// op codes written to the command register
`define PEWS_OP_NONE 3'h0
`define PEWS_OP_LOAD 3'h1
`define PEWS_OP_READ 3'h2
`define PEWS_OP_POLL 3'h3
`define PEWS_OP_PROT 3'h4
`define PEWS_OP_UNPROT 3'h5
`define PEWS_OP_ERASE 3'h6

// status bit positions
`define PEWS_ST_BUSY 0
`define PEWS_ST_PAGE_OPEN 1
`define PEWS_ST_POLL_OK 2
`define PEWS_ST_ERR_PAGE 3
`define PEWS_ST_ERR_BUSY 4
`define PEWS_ST_WRITE_PEND 5
`define PEWS_ST_PROT_ON 6
`define PEWS_ST_ERR_LOCK 7

// timing
`define PEWS_CLK_MHZ 125
`define PEWS_CLK_NS 8
`define PEWS_BLC_US 100
`define PEWS_BLCO_US 200
`define PEWS_WR_LOW_NS 30
`define PEWS_RD_ACC_NS 100
`define PEWS_SYNC_LAT 3

// sequence lengths
`define PEWS_PROT_LEN 3
`define PEWS_LONG_LEN 6
`define PEWS_CONFIRM 2'h2

`endif

// [logic/pews_pkg.sv]
// types of the page write host controller
// assumes pews_cfg.svh for all numeric constants
package pews_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WSET,
        ST_WLOW,
        ST_WREL,
        ST_WGAP,
        ST_WAIT,
        ST_RSET,
        ST_RLOW,
        ST_RREL,
        ST_EVAL
    } pews_state_e;

    typedef struct packed {
        pews_state_e st;
        logic [2:0] op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [31:0] prdata;
        logic [15:0] pin_addr;
        logic [7:0] pin_data;
        logic sel_n;
        logic rd_n;
        logic wr_n;
        logic oe;
        logic [7:0] cnt;
        logic [2:0] idx;
        logic [15:0] win;
        logic page_open;
        logic has_data;
        logic [8:0] page;
        logic [15:0] last_addr;
        logic [7:0] last_data;
        logic write_pend;
        logic prot_on;
        logic armed;
        logic erase_mode;
        logic poll_ok;
        logic err_page;
        logic err_busy;
        logic err_lock;
        logic prev6;
        logic first;
        logic [1:0] conf;
    } pews_state_s;

endpackage

// [logic/pews_pin_if.sv]
// carrier between the controller and its pin input synchroniser
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface pews_pin_if;
    logic [7:0] raw;
    logic [7:0] stable;
    modport host (output raw, input stable);
    modport sync (input raw, output stable);
endinterface
`default_nettype wire

// [logic/pews_in_sync.sv]
// three-stage synchroniser for the flash data pins
// assumes raw data comes from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pews_in_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pews_pin_if.sync pins
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stable_q <= '0;
        end else begin
            s1_q <= pins.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                stable_q <= s3_q;
            end
        end
    end

    assign pins.stable = stable_q;

endmodule
`default_nettype wire

// [logic/pews_host.sv]
// host controller driving the byte-wide pins of a page-mode flash, ordered over apb
// assumes one 125 MHz clock and a flash whose timers run on their own
//
// Overview of operation
// - every byte of one page load carries the same page address bits.
// - each further byte load must start within 100 us of the previous.
// - during a write only the repeated status reads of a poll are issued.
// - on an odd status result re-read twice; accept only if both valid.
// - while protected every write is preceded by the three-byte sequence.
// - only the six-byte sequence returns the flash to unprotected mode.
// - data is driven only while select is low and read is high on a write.
`timescale 1ns/100ps
`default_nettype none
`include "pews_cfg.svh"
module pews_host #(
    parameter int BLC_CYC = `PEWS_BLC_US * `PEWS_CLK_MHZ,
    parameter int BLCO_CYC = `PEWS_BLCO_US * `PEWS_CLK_MHZ,
    // sequence tables, entry i at bits [24*(len-1-i) +: 24] as {address, data}, first entry in the top bits; values arbitrary
    parameter logic [71:0] PROT_SEQ = 72'h0001A1_0002A2_0003A3,
    parameter logic [143:0] UNPROT_SEQ = 144'h0011B1_0012B2_0013B3_0014B4_0015B5_0016B6,
    parameter logic [143:0] ERASE_SEQ = 144'h0021C1_0022C2_0023C3_0024C4_0025C5_0026C6
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic BYTE_MEMORY_SELECT_N_O,
    output logic MEM_RD_N_O,
    output logic MEM_WR_N_O,
    output logic [15:0] MEM_ADDR_O,
    input wire logic [7:0] MEM_DATA_I,
    output logic [7:0] MEM_DATA_O,
    output logic MEM_DATA_OE_O
);

    localparam int WR_CYC = (`PEWS_WR_LOW_NS + `PEWS_CLK_NS - 1) / `PEWS_CLK_NS;
    localparam int RD_CYC = (`PEWS_RD_ACC_NS + `PEWS_CLK_NS - 1) / `PEWS_CLK_NS + `PEWS_SYNC_LAT;

    pews_pkg::pews_state_s s_q;
    pews_pkg::pews_state_s s_d;
    pews_pin_if pin_bus ();
    logic apb_wr;
    logic apb_setup;
    logic map_hit;

    assign pin_bus.raw = MEM_DATA_I;

    pews_in_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .pins(pin_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [23:0] seq_word(input logic [2:0] op, input logic [2:0] idx);
        logic [23:0] w;
        w = 24'h000000;
        case (op)
            `PEWS_OP_PROT: w = PROT_SEQ[(`PEWS_PROT_LEN - 1 - int'(idx)) * 24 +: 24];
            `PEWS_OP_UNPROT: w = UNPROT_SEQ[(`PEWS_LONG_LEN - 1 - int'(idx)) * 24 +: 24];
            `PEWS_OP_ERASE: w = ERASE_SEQ[(`PEWS_LONG_LEN - 1 - int'(idx)) * 24 +: 24];
            default: w = 24'h000000;
        endcase
        return w;
    endfunction

    function automatic logic [2:0] seq_last(input logic [2:0] op);
        return (op == `PEWS_OP_PROT) ? 3'(`PEWS_PROT_LEN - 1) : 3'(`PEWS_LONG_LEN - 1);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == `PEWS_REG_CMD) || (a == `PEWS_REG_ADDR) || (a == `PEWS_REG_WDATA) ||
               (a == `PEWS_REG_STATUS) || (a == `PEWS_REG_RDATA);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign map_hit = is_mapped(PADDR_I);

    always_comb begin
        logic ok;
        logic [23:0] w;
        ok = 1'b0;
        w = 24'h000000;
        s_d = s_q;

        // load window and timeout both measured from the last byte's release
        if (s_q.win < 16'(BLCO_CYC)) begin
            s_d.win = s_q.win + 16'h0001;
        end
        if (s_q.page_open && s_q.win >= 16'(BLC_CYC)) begin
            s_d.page_open = 1'b0;
            s_d.armed = 1'b0;
            s_d.has_data = 1'b0;
            if (s_q.has_data) begin
                s_d.write_pend = 1'b1;
            end
        end

        // apb read data captured in the setup cycle
        if (apb_setup && !PWRITE_I) begin
            case (PADDR_I)
                `PEWS_REG_CMD: s_d.prdata = {29'h0, s_q.op};
                `PEWS_REG_ADDR: s_d.prdata = {16'h0, s_q.addr};
                `PEWS_REG_WDATA: s_d.prdata = {24'h0, s_q.wdata};
                `PEWS_REG_STATUS: s_d.prdata = {24'h0, s_q.err_lock, s_q.prot_on, s_q.write_pend,
                    s_q.err_busy, s_q.err_page, s_q.poll_ok, s_q.page_open, s_q.st != pews_pkg::ST_IDLE};
                `PEWS_REG_RDATA: s_d.prdata = {24'h0, s_q.rdata};
                default: s_d.prdata = 32'h0;
            endcase
        end

        if (apb_wr) begin
            case (PADDR_I)
                `PEWS_REG_ADDR: s_d.addr = PWDATA_I[15:0];
                `PEWS_REG_WDATA: s_d.wdata = PWDATA_I[7:0];
                `PEWS_REG_CMD: begin
                    // a new command clears the sticky errors; refusals below set them again
                    s_d.err_page = 1'b0;
                    s_d.err_busy = 1'b0;
                    s_d.err_lock = 1'b0;
                    if (s_q.st != pews_pkg::ST_IDLE) begin
                        s_d.err_busy = 1'b1;
                    end else begin
                        s_d.op = PWDATA_I[2:0];
                        s_d.idx = 3'h0;
                        s_d.cnt = 8'h00;
                        case (PWDATA_I[2:0])
                            `PEWS_OP_LOAD: begin
                                if (s_q.write_pend) begin
                                    s_d.err_busy = 1'b1;
                                end else if (s_q.prot_on && !s_q.armed) begin
                                    s_d.err_lock = 1'b1;
                                end else if (s_q.has_data && s_q.addr[15:7] != s_q.page) begin
                                    s_d.err_page = 1'b1;
                                end else begin
                                    s_d.page = s_q.addr[15:7];
                                    s_d.has_data = 1'b1;
                                    s_d.last_addr = s_q.addr;
                                    s_d.last_data = s_q.wdata;
                                    s_d.poll_ok = 1'b0;
                                    s_d.pin_addr = s_q.addr;
                                    s_d.pin_data = s_q.wdata;
                                    s_d.sel_n = 1'b0;
                                    s_d.st = pews_pkg::ST_WSET;
                                end
                            end
                            `PEWS_OP_READ: begin
                                if (s_q.write_pend) begin
                                    s_d.err_busy = 1'b1;
                                end else begin
                                    s_d.pin_addr = s_q.addr;
                                    s_d.sel_n = 1'b0;
                                    s_d.st = pews_pkg::ST_RSET;
                                end
                            end
                            `PEWS_OP_POLL: begin
                                s_d.conf = 2'h0;
                                s_d.first = 1'b1;
                                if (!s_q.write_pend && !s_q.page_open) begin
                                    s_d.poll_ok = 1'b1;
                                end else begin
                                    s_d.st = pews_pkg::ST_WAIT;
                                end
                            end
                            `PEWS_OP_PROT, `PEWS_OP_UNPROT, `PEWS_OP_ERASE: begin
                                if (s_q.write_pend || s_q.has_data) begin
                                    s_d.err_busy = 1'b1;
                                end else begin
                                    w = seq_word(PWDATA_I[2:0], 3'h0);
                                    s_d.pin_addr = w[23:8];
                                    s_d.pin_data = w[7:0];
                                    s_d.poll_ok = 1'b0;
                                    s_d.sel_n = 1'b0;
                                    s_d.st = pews_pkg::ST_WSET;
                                end
                            end
                            default: s_d.err_busy = 1'b1;
                        endcase
                    end
                end
                default: s_d.addr = s_q.addr;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////
        // pin sequencer
        case (s_q.st)
            pews_pkg::ST_IDLE: s_d.cnt = 8'h00;
            pews_pkg::ST_WSET: begin
                // write falls after select, so the flash takes the address here
                s_d.wr_n = 1'b0;
                s_d.oe = 1'b1;
                s_d.cnt = 8'h00;
                s_d.st = pews_pkg::ST_WLOW;
            end
            pews_pkg::ST_WLOW: begin
                if (s_q.cnt == 8'(WR_CYC - 1)) begin
                    // write rises first, data still driven, select still low
                    s_d.wr_n = 1'b1;
                    s_d.st = pews_pkg::ST_WREL;
                end else begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end
            pews_pkg::ST_WREL: begin
                s_d.sel_n = 1'b1;
                s_d.oe = 1'b0;
                s_d.win = 16'h0000;
                s_d.page_open = 1'b1;
                s_d.st = pews_pkg::ST_WGAP;
            end
            pews_pkg::ST_WGAP: begin
                if (s_q.op != `PEWS_OP_LOAD && s_q.idx != seq_last(s_q.op)) begin
                    w = seq_word(s_q.op, s_q.idx + 3'h1);
                    s_d.idx = s_q.idx + 3'h1;
                    s_d.pin_addr = w[23:8];
                    s_d.pin_data = w[7:0];
                    s_d.sel_n = 1'b0;
                    s_d.st = pews_pkg::ST_WSET;
                end else begin
                    s_d.st = pews_pkg::ST_IDLE;
                    case (s_q.op)
                        `PEWS_OP_PROT: begin
                            s_d.prot_on = 1'b1;
                            s_d.armed = 1'b1;
                        end
                        `PEWS_OP_UNPROT: begin
                            s_d.prot_on = 1'b0;
                            s_d.has_data = 1'b1;
                            s_d.last_addr = s_q.pin_addr;
                            s_d.last_data = s_q.pin_data;
                        end
                        `PEWS_OP_ERASE: begin
                            s_d.has_data = 1'b1;
                            s_d.erase_mode = 1'b1;
                            s_d.last_addr = s_q.pin_addr;
                        end
                        default: s_d.armed = s_q.armed;
                    endcase
                end
            end
            pews_pkg::ST_WAIT: begin
                // polling before the flash timeout would read the buffer, not the status
                if (!s_q.page_open && s_q.win >= 16'(BLCO_CYC)) begin
                    s_d.pin_addr = s_q.last_addr;
                    s_d.sel_n = 1'b0;
                    s_d.st = pews_pkg::ST_RSET;
                end
            end
            pews_pkg::ST_RSET: begin
                s_d.rd_n = 1'b0;
                s_d.cnt = 8'h00;
                s_d.st = pews_pkg::ST_RLOW;
            end
            pews_pkg::ST_RLOW: begin
                if (s_q.cnt == 8'(RD_CYC - 1)) begin
                    s_d.rdata = pin_bus.stable;
                    s_d.rd_n = 1'b1;
                    s_d.st = pews_pkg::ST_RREL;
                end else begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end
            pews_pkg::ST_RREL: begin
                s_d.sel_n = 1'b1;
                s_d.st = (s_q.op == `PEWS_OP_POLL) ? pews_pkg::ST_EVAL : pews_pkg::ST_IDLE;
            end
            pews_pkg::ST_EVAL: begin
                // bit 7 must equal bit 7 of the last byte written, except in erase mode, and bit 6 must have stopped alternating
                ok = !s_q.first && (s_q.rdata[6] == s_q.prev6) &&
                     (s_q.erase_mode || s_q.rdata[7] == s_q.last_data[7]);
                s_d.prev6 = s_q.rdata[6];
                s_d.first = 1'b0;
                if (ok && s_q.conf == `PEWS_CONFIRM) begin
                    s_d.poll_ok = 1'b1;
                    s_d.write_pend = 1'b0;
                    s_d.erase_mode = 1'b0;
                    s_d.st = pews_pkg::ST_IDLE;
                end else begin
                    s_d.conf = ok ? s_q.conf + 2'h1 : 2'h0;
                    s_d.sel_n = 1'b0;
                    s_d.st = pews_pkg::ST_RSET;
                end
            end
            default: s_d.st = pews_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            s_q <= '0;
            s_q.st <= pews_pkg::ST_IDLE;
            s_q.sel_n <= 1'b1;
            s_q.rd_n <= 1'b1;
            s_q.wr_n <= 1'b1;
            s_q.win <= 16'hFFFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA_O = s_q.prdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~map_hit;
    assign BYTE_MEMORY_SELECT_N_O = s_q.sel_n;
    assign MEM_RD_N_O = s_q.rd_n;
    assign MEM_WR_N_O = s_q.wr_n;
    assign MEM_ADDR_O = s_q.pin_addr;
    assign MEM_DATA_O = s_q.pin_data;
    assign MEM_DATA_OE_O = s_q.oe;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);

    property p_drive_only_writing;
        s_q.oe |-> s_q.rd_n && !s_q.sel_n && $past(!s_q.sel_n);
    endproperty
    a_drive_only_writing: assert property (p_drive_only_writing) else $error("data driven outside a write");

    property p_same_page;
        (s_q.st == pews_pkg::ST_WLOW && s_q.op == `PEWS_OP_LOAD) |-> s_q.pin_addr[15:7] == s_q.page;
    endproperty
    a_same_page: assert property (p_same_page) else $error("byte load left the open page");

    property p_window;
        s_q.page_open |-> s_q.win <= 16'(BLC_CYC);
    endproperty
    a_window: assert property (p_window) else $error("page held open past the load window");

    property p_status_reads_only;
        (s_q.st == pews_pkg::ST_RSET && s_q.write_pend) |-> s_q.op == `PEWS_OP_POLL;
    endproperty
    a_status_reads_only: assert property (p_status_reads_only) else $error("plain read during write");

    property p_confirm_twice;
        ($rose(s_q.poll_ok) && $past(s_q.write_pend)) |-> $past(s_q.conf) == `PEWS_CONFIRM && !s_q.write_pend;
    endproperty
    a_confirm_twice: assert property (p_confirm_twice) else $error("completion taken without two re-reads");

    property p_armed_load;
        (s_q.st == pews_pkg::ST_WSET && s_q.op == `PEWS_OP_LOAD && s_q.prot_on) |-> s_q.armed;
    endproperty
    a_armed_load: assert property (p_armed_load) else $error("protected load without protect sequence");

    property p_unprotect;
        $fell(s_q.prot_on) |-> $past(s_q.op) == `PEWS_OP_UNPROT && $past(s_q.st) == pews_pkg::ST_WGAP;
    endproperty
    a_unprotect: assert property (p_unprotect) else $error("protection dropped without unprotect sequence");

    property p_wr_width;
        $fell(s_q.wr_n) |-> !s_q.wr_n[*4] ##1 s_q.wr_n;
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");

endmodule
`default_nettype wire

// [verif/pews_flash_model.sv]
// behavioural flash: page buffer, load timeout, timed page write, status bits
// assumes registered host pins sampled on the host clock
`timescale 1ns/100ps
`default_nettype none
module pews_flash_model #(
    parameter int TO_CYC = 60,
    parameter int WR_CYC = 400,
    // last {address, data} of the host's erase table; must match the host parameter
    parameter logic [23:0] ERASE_LAST = 24'h0026C6
) (
    input wire logic clk_i,
    input wire logic sel_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic oe_i,
    output logic [7:0] data_o
);
    logic [7:0] mem [65536];
    logic [7:0] pg [128];
    logic [127:0] got = '0;
    logic [15:0] a = '0;
    logic [7:0] ld = '0;
    logic [7:0] dout = '0;
    logic [8:0] page = '0;
    logic s_q = 1'b1;
    logic r_q = 1'b1;
    logic open = 1'b0;
    logic tog = 1'b1;
    int tmr = 0;
    int busy = 0;
    logic [7:0] bus_w;
    // undriven data pins show the inverse, so a missing enable corrupts the byte
    assign bus_w = oe_i ? data_i : ~data_i;
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h5A;
    end
    always @(posedge clk_i) begin
        s_q <= sel_n_i | wr_n_i;
        r_q <= sel_n_i | rd_n_i;
        tmr <= tmr + 1;
        if (s_q && !(sel_n_i | wr_n_i) && rd_n_i) a <= addr_i;
        if (!s_q && (sel_n_i | wr_n_i) && busy == 0) begin
            pg[a[6:0]] <= bus_w;
            got[a[6:0]] <= 1'b1;
            page <= a[15:7];
            ld <= bus_w;
            open <= 1'b1;
            tmr <= 0;
            tog <= 1'b1;
        end
        if (open && tmr == TO_CYC) begin
            open <= 1'b0;
            busy <= WR_CYC;
        end
        if (busy == 1) begin
            if ({a, ld} == ERASE_LAST) begin
                for (int i = 0; i < 65536; i++) mem[i] <= 8'hFF;
            end else begin
                for (int i = 0; i < 128; i++) mem[{page, i[6:0]}] <= got[i] ? pg[i] : 8'hFF;
            end
            got <= '0;
        end
        if (busy > 0) busy <= busy - 1;
        if (r_q && !(sel_n_i | rd_n_i)) begin
            if (busy > 0) begin
                dout <= {~ld[7], tog, ld[5:0]};
                tog <= ~tog;
            end else dout <= mem[addr_i];
        end
    end
    // released bus shows the inverse so a stale value never passes
    assign data_o = (!sel_n_i && !rd_n_i) ? dout : ~dout;
endmodule
`default_nettype wire

// [verif/page_eeprom_write_sequencer_test.sv]
// testbench: apb master, flash model on the pins, page load and readback
// assumes pews_cfg.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "pews_cfg.svh"
module page_eeprom_write_sequencer_test;
    logic clk, rst, psel, pen, pwr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [31:0] prdata;
    logic prdy, perr, sel_n, rd_n, wr_n, oe;
    logic [15:0] maddr;
    logic [7:0] din, dout;
    int err_total = 0;
    int n_compared = 0;
    pews_host #(.BLC_CYC(50), .BLCO_CYC(100)) pews_host_i (.CLOCK_I(clk), .RESET_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(prdy), .PSLVERR_O(perr), .BYTE_MEMORY_SELECT_N_O(sel_n),
        .MEM_RD_N_O(rd_n), .MEM_WR_N_O(wr_n), .MEM_ADDR_O(maddr), .MEM_DATA_I(din),
        .MEM_DATA_O(dout), .MEM_DATA_OE_O(oe));
    pews_flash_model pews_flash_model_i (.clk_i(clk), .sel_n_i(sel_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .addr_i(maddr), .data_i(dout), .oe_i(oe), .data_o(din));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the watchdog ends a wait for ready
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prdata;
        slv = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // status is polled so no command lands while busy
    task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, `PEWS_REG_ADDR, {16'h0000, a});
        apb(1'b1, `PEWS_REG_WDATA, {24'h000000, d});
        apb(1'b1, `PEWS_REG_CMD, {29'h00000000, op});
        do begin
            apb(1'b0, `PEWS_REG_STATUS, 32'h00000000);
        end while (rd[0] !== 1'b0);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        cmd(`PEWS_OP_READ, a, 8'h00);
        apb(1'b0, `PEWS_REG_RDATA, 32'h00000000);
        chk("read byte", {24'h000000, e}, rd);
    endtask
    task automatic t_reset;
        apb(1'b0, `PEWS_REG_STATUS, 32'h00000000);
        chk("status", 32'h00000000, rd);
        apb(1'b0, 12'h014, 32'h00000000);
        chk("pslverr", 32'h00000001, {31'h00000000, slv});
        chk("unmapped", 32'h00000000, rd);
    endtask
    task automatic t_page;
        cmd(`PEWS_OP_LOAD, 16'h0105, 8'h3C);
        cmd(`PEWS_OP_LOAD, 16'h0105, 8'h81);
        cmd(`PEWS_OP_LOAD, 16'h0110, 8'h42);
        cmd(`PEWS_OP_LOAD, 16'h0290, 8'h11);
        chk("err_page", 32'h00000001, {31'h00000000, rd[3]});
        cmd(`PEWS_OP_POLL, 16'h0000, 8'h00);
        chk("poll_ok", 32'h00000001, {31'h00000000, rd[2]});
        rdchk(16'h0105, 8'h81);
        rdchk(16'h0110, 8'h42);
        rdchk(16'h0100, 8'hFF);
        rdchk(16'h0290, 8'h5A);
    endtask
    // waits let the load window lapse so arming and write pending change
    task automatic t_lock;
        cmd(`PEWS_OP_PROT, 16'h0000, 8'h00);
        chk("prot_on", 32'h00000001, {31'h00000000, rd[6]});
        repeat (60) @(posedge clk);
        cmd(`PEWS_OP_LOAD, 16'h0300, 8'h24);
        chk("err_lock", 32'h00000001, {31'h00000000, rd[7]});
        cmd(`PEWS_OP_UNPROT, 16'h0000, 8'h00);
        chk("prot_off", 32'h00000000, {31'h00000000, rd[6]});
        repeat (60) @(posedge clk);
        cmd(`PEWS_OP_READ, 16'h0300, 8'h00);
        chk("err_busy", 32'h00000001, {31'h00000000, rd[4]});
        cmd(`PEWS_OP_POLL, 16'h0000, 8'h00);
        chk("unprot poll_ok", 32'h00000001, {31'h00000000, rd[2]});
        cmd(`PEWS_OP_ERASE, 16'h0000, 8'h00);
        cmd(`PEWS_OP_POLL, 16'h0000, 8'h00);
        chk("erase poll_ok", 32'h00000001, {31'h00000000, rd[2]});
        rdchk(16'h0290, 8'hFF);
    endtask
    task automatic complete_run;
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_page;
        t_lock;
        complete_run;
    end
    initial begin
        #400000;
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
